// >>> src/lin_dynamic_id_assignment.sv
// dynamic identifier table, command decode and read-answer decision for a LIN node
// assumes headers and frames arrive parsed, on CLK, one pulse each; AXI4-Lite master on CLK
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module lin_dynamic_id_assignment
(
   input  wire logic                      CLK,
   input  wire logic                      RESETN,
   input  wire lin_dyn_pkg::header_type   HDR,
   input  wire lin_dyn_pkg::frame_type    FRAME,
   output var  lin_dyn_pkg::response_type RESP,
   output var  lin_dyn_pkg::command_type  CMD,
   input  wire logic [7:0]                S_AXI_AWADDR,
   input  wire logic                      S_AXI_AWVALID,
   output logic                           S_AXI_AWREADY,
   input  wire logic [31:0]               S_AXI_WDATA,
   input  wire logic [3:0]                S_AXI_WSTRB,
   input  wire logic                      S_AXI_WVALID,
   output logic                           S_AXI_WREADY,
   output logic [1:0]                     S_AXI_BRESP,
   output logic                           S_AXI_BVALID,
   input  wire logic                      S_AXI_BREADY,
   input  wire logic [7:0]                S_AXI_ARADDR,
   input  wire logic                      S_AXI_ARVALID,
   output logic                           S_AXI_ARREADY,
   output logic [31:0]                    S_AXI_RDATA,
   output logic [1:0]                     S_AXI_RRESP,
   output logic                           S_AXI_RVALID,
   input  wire logic                      S_AXI_RREADY
);
   import lin_dyn_pkg::*;

   logic [5:0] tbl_id [NUM_SLOTS];
   logic [NUM_SLOTS-1:0] tbl_valid;
   logic [6:0] node_addr;
   logic       prep_armed;
   logic [6:0] prep_cmd;
   logic [7:0] assign_count;
   logic [7:0] drop_count;

   logic       f_ok, h_ok, app_frame, addressed, assign_go, prep_go;
   logic [6:0] app_code, next_prep_cmd;
   logic [5:0] fid, hid;
   logic [3:0] ptr [4];
   logic [5:0] nid [4];
   logic [NUM_SLOTS-1:0] f_hit, h_hit;
   logic [3:0] f_slot, h_slot;
   logic [2:0] drops;

   function automatic logic id_match(input logic [5:0] rx, input logic [5:0] stored, input logic by_addr,
                                     input logic [2:0] na);
      // address slots: upper bits from the table, low three from this node
      id_match = by_addr ? (rx[5:3] == stored[5:3] && rx[2:0] == na) : (rx == stored); // RL14
   endfunction

   function automatic logic pair_ok(input logic [3:0] p, input logic [5:0] i);
      pair_ok = (p < 4'(NUM_SLOTS)) && i != ID_CMD && i != ID_EXT; // RL18 RL2
   endfunction

   always_comb
   begin
      fid = FRAME.pid[5:0];
      hid = HDR.pid[5:0];
      f_ok = FRAME.valid && pid_ok(FRAME.pid); // RL1
      h_ok = HDR.valid && pid_ok(HDR.pid); // RL1
      // broadcast contents below the marker are not ours to interpret
      app_frame = f_ok && fid == ID_CMD && FRAME.data[1] == APP_MARK && FRAME.data[2][7]; // RL7 RL15
      app_code = FRAME.data[2][6:0];
      addressed = !FRAME.data[3][7] || FRAME.data[3][6:0] == node_addr; // RL6
      assign_go = app_frame && app_code == CMD_ASSIGN && addressed; // RL3
      ptr[0] = FRAME.data[4][3:0]; // RL8
      nid[0] = {FRAME.data[5][1:0], FRAME.data[4][7:4]}; // RL8
      ptr[1] = FRAME.data[5][5:2]; // RL8
      nid[1] = {FRAME.data[6][3:0], FRAME.data[5][7:6]}; // RL8 RL9
      ptr[2] = FRAME.data[6][7:4]; // RL9
      nid[2] = FRAME.data[7][5:0]; // RL9
      ptr[3] = {FRAME.data[8][1:0], FRAME.data[7][7:6]}; // RL9
      nid[3] = FRAME.data[8][7:2]; // RL9
      drops = 3'h0;
      for (int k = 0; k < 4; k++)
      begin
         drops = drops + 3'(!pair_ok(ptr[k], nid[k]));
      end
      for (int s = 0; s < NUM_SLOTS; s++)
      begin
         f_hit[s] = tbl_valid[s] && id_match(fid, tbl_id[s], ADDR_SLOTS[s], node_addr[2:0]);
         h_hit[s] = tbl_valid[s] && id_match(hid, tbl_id[s], ADDR_SLOTS[s], node_addr[2:0]);
      end
      f_slot = 4'h0;
      h_slot = 4'h0;
      for (int s = NUM_SLOTS - 1; s >= 0; s--)
      begin
         if (f_hit[s])
         begin
            f_slot = 4'(s);
         end
         if (h_hit[s])
         begin
            h_slot = 4'(s);
         end
      end
      // read codes 0x00 to 0x02 in a 0x3C frame, or a slot-8 frame, prepare an indirect answer
      prep_go = 1'b0;
      next_prep_cmd = app_code;
      if (app_frame && app_code <= CMD_RFUSE && FRAME.data[3][7] && FRAME.data[3][6:0] == node_addr)
      begin
         prep_go = 1'b1;
      end
      else if (f_ok && f_hit != '0 && f_slot == SLOT_PREP && FRAME.data[1][7]
               && FRAME.data[2][6:0] == node_addr) // RL11
      begin
         prep_go = 1'b1;
         next_prep_cmd = FRAME.data[1][6:0];
      end
   end

   // later pairs of one frame win over earlier ones aimed at the same slot
   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         tbl_valid <= '0;
         for (int s = 0; s < NUM_SLOTS; s++)
         begin
            tbl_id[s] <= 6'h00;
         end
      end
      else if (assign_go) // RL6 RL17
      begin
         for (int k = 0; k < 4; k++) // RL4
         begin
            if (pair_ok(ptr[k], nid[k])) // RL18 RL2
            begin
               tbl_id[ptr[k]] <= nid[k]; // RL5 RL17
               tbl_valid[ptr[k]] <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         assign_count <= 8'h00;
         drop_count <= 8'h00;
      end
      else if (assign_go)
      begin
         assign_count <= assign_count + 8'h01;
         drop_count <= drop_count + {5'h00, drops};
      end
   end

   // a frame completing and a header in one cycle: the arming wins
   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         prep_armed <= 1'b0;
         prep_cmd <= CMD_NONE;
      end
      else if (prep_go)
      begin
         prep_armed <= 1'b1;
         prep_cmd <= next_prep_cmd;
      end
      else if (h_ok)
      begin
         prep_armed <= 1'b0; // RL16
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         RESP <= '0;
      end
      else
      begin
         RESP.valid <= 1'b0;
         if (h_ok && hid == ID_READ && prep_armed) // RL16
         begin
            RESP <= '{valid: 1'b1, indirect: 1'b1, slot: SLOT_PREP, cmd: prep_cmd, frame_id: hid};
         end
         else if (h_ok && hid != ID_READ && h_hit != '0 && (h_slot == SLOT_RPOS || h_slot == SLOT_RBRIEF)) // RL10
         begin
            RESP <= '{valid: 1'b1, indirect: 1'b0, slot: h_slot, cmd: slot_code(h_slot), frame_id: hid}; // RL14
         end
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         CMD <= '0;
      end
      else
      begin
         CMD.valid <= 1'b0;
         if (app_frame && addressed && app_code != CMD_ASSIGN && app_code > CMD_RBRIEF) // RL12 RL13
         begin
            CMD <= '{valid: 1'b1, from_slot: 1'b0, known: cmd_known(app_code), slot: 4'h0, code: app_code};
         end
         else if (f_ok && fid != ID_CMD && f_hit != '0 && f_slot != SLOT_PREP && f_slot != SLOT_RPOS
                  && f_slot != SLOT_RBRIEF)
         begin
            // general purpose slots carry their command in the first data byte
            if (f_slot == SLOT_GP2 || f_slot == SLOT_GP4) // RL10
            begin
               CMD <= '{valid: 1'b1, from_slot: 1'b1, known: cmd_known(FRAME.data[1][6:0]), slot: f_slot,
                        code: FRAME.data[1][6:0]};
            end
            else
            begin
               CMD <= '{valid: 1'b1, from_slot: 1'b1, known: 1'b1, slot: f_slot, code: slot_code(f_slot)}; // RL11
            end
         end
      end
   end

   logic       aw_got, w_got;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY <= 1'b0;
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= RESP_OKAY;
         node_addr <= NODE_RESET;
      end
      else
      begin
         if (S_AXI_AWVALID && S_AXI_AWREADY)
         begin
            S_AXI_AWREADY <= 1'b0;
            aw_got <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
         end
         else if (!aw_got && !S_AXI_BVALID)
         begin
            S_AXI_AWREADY <= 1'b1;
         end
         if (S_AXI_WVALID && S_AXI_WREADY)
         begin
            S_AXI_WREADY <= 1'b0;
            w_got <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
         end
         else if (!w_got && !S_AXI_BVALID)
         begin
            S_AXI_WREADY <= 1'b1;
         end
         if (aw_got && w_got && !S_AXI_BVALID)
         begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= RESP_SLVERR;
            if (aw_addr[7:2] == OFS_NODE[7:2])
            begin
               S_AXI_BRESP <= RESP_OKAY;
               if (w_strb[0])
               begin
                  node_addr <= w_data[6:0];
               end
            end
         end
         else if (S_AXI_BVALID && S_AXI_BREADY)
         begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end

   logic [3:0] rd_index;
   assign rd_index = 4'(S_AXI_ARADDR[7:2] - OFS_TABLE[7:2]);

   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0;
         S_AXI_RRESP <= RESP_OKAY;
      end
      else if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA <= 32'h0;
         S_AXI_RRESP <= RESP_OKAY;
         if (S_AXI_ARADDR[7:2] == OFS_NODE[7:2])
         begin
            S_AXI_RDATA <= {25'h0, node_addr};
         end
         else if (S_AXI_ARADDR[7:2] == OFS_STATUS[7:2])
         begin
            S_AXI_RDATA <= {8'h00, drop_count, assign_count, 7'h00, prep_armed};
         end
         else if (S_AXI_ARADDR[7:2] >= OFS_TABLE[7:2] && rd_index < 4'(NUM_SLOTS))
         begin
            S_AXI_RDATA <= {23'h0, tbl_valid[rd_index], 2'h0, tbl_id[rd_index]};
         end
         else
         begin
            S_AXI_RRESP <= RESP_SLVERR;
         end
      end
      else if (S_AXI_RVALID && S_AXI_RREADY)
      begin
         S_AXI_RVALID <= 1'b0;
      end
      else if (!S_AXI_RVALID)
      begin
         S_AXI_ARREADY <= 1'b1;
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);

   logic any_reserved;
   always_comb
   begin
      any_reserved = 1'b0;
      for (int s = 0; s < NUM_SLOTS; s++)
      begin
         any_reserved = any_reserved | (tbl_valid[s] && (tbl_id[s] == ID_CMD || tbl_id[s] == ID_EXT));
      end
   end

   sequence s_prepared;
      prep_go ##1 prep_armed;
   endsequence
   sequence s_read_hdr;
      h_ok && hid == ID_READ && !prep_go;
   endsequence

   property p_reserved;
      !any_reserved;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved id stored in table"); // RL2

   property p_last_pair;
      assign_go && pair_ok(ptr[3], nid[3]) |=> tbl_valid[$past(ptr[3])] && tbl_id[$past(ptr[3])] == $past(nid[3]);
   endproperty
   a_last_pair: assert property (p_last_pair) else $error("fourth pair not stored"); // RL5

   property p_foreign;
      app_frame && app_code == CMD_ASSIGN && FRAME.data[3][7] && FRAME.data[3][6:0] != node_addr
      |=> $stable(tbl_valid) && $stable(tbl_id[0]) && $stable(tbl_id[9]);
   endproperty
   a_foreign: assert property (p_foreign) else $error("table changed by foreign frame"); // RL6

   property p_bad_ptrs;
      assign_go && ptr[0] > 4'h9 && ptr[1] > 4'h9 && ptr[2] > 4'h9 && ptr[3] > 4'h9
      |=> $stable(tbl_valid) && drop_count == $past(drop_count) + 8'h04;
   endproperty
   a_bad_ptrs: assert property (p_bad_ptrs) else $error("out of range pointer not dropped"); // RL18

   property p_indirect;
      s_prepared ##0 (!h_ok) [*1] ##1 s_read_hdr |=> RESP.valid && RESP.indirect;
   endproperty
   a_indirect: assert property (p_indirect) else $error("indirect read not answered"); // RL16

   property p_unprepared;
      (s_read_hdr and !prep_armed) |=> !RESP.valid;
   endproperty
   a_unprepared: assert property (p_unprepared) else $error("unprepared indirect read answered"); // RL16

   property p_node_bits;
      RESP.valid && !RESP.indirect |-> RESP.frame_id[2:0] == node_addr[2:0];
   endproperty
   a_node_bits: assert property (p_node_bits) else $error("direct answer for another node"); // RL14

   property p_parity;
      FRAME.valid && !pid_ok(FRAME.pid) && !HDR.valid |=> !CMD.valid && !RESP.valid && $stable(tbl_valid);
   endproperty
   a_parity: assert property (p_parity) else $error("frame with bad parity acted on"); // RL1

   property p_decode;
      CMD.valid && !CMD.from_slot |-> CMD.known == cmd_known(CMD.code) && CMD.code != CMD_ASSIGN;
   endproperty
   a_decode: assert property (p_decode) else $error("command code decoded wrongly"); // RL13
endmodule
`default_nettype wire

// >>> src/lin_dyn_pkg.sv
// Summary of operation
// (RL1) Identifier is six id bits plus two parity bits; content follows the id.
// (RL2) Ids 0x3C and 0x3F are reserved and never stored as assigned ids.
// (RL3) Assignment frame on id 0x3C stores carried ids into the table.
// (RL4) One assignment frame carries exactly four pointer/id pairs.
// (RL5) Each 4-bit pointer selects the table slot that takes its 6-bit id.
// (RL6) All-nodes flag 0: every node stores; flag 1: only the address match.
// (RL7) Byte1 0x80 marker, byte2 bit7 plus code 0x11, byte3 flag and address.
// (RL8) Bytes 4 and 5 pack id1, pointer1, pointer2 and the low id2 bits.
// (RL9) Bytes 6 to 8 pack pointer3, id2 high, id3, pointer4 and id4.
// (RL10) Pointers 0-7 map general purpose, reads, moves and compact moves.
// (RL11) Pointer 8 is the preparing frame, pointer 9 move_with_settings.
// (RL12) Read, motion and stop command codes decode as listed.
// (RL13) Settings, move and assignment command codes decode as listed.
// (RL14) Address-carrying ids answer only when low three bits equal the node address.
// (RL15) Master sets bit7 of first data byte in application frames.
// (RL16) Indirect read answered only right after a preparing frame for this node.
// (RL17) Rewriting a slot replaces it; foreign addressed frames change nothing.
// (RL18) Pairs with pointers beyond the ten slots are dropped.
// assumes a LIN data-link layer on the same clock delivering parsed headers and frames
`default_nettype none
package lin_dyn_pkg;
   localparam int         NUM_SLOTS = 10;
   localparam logic [5:0] ID_CMD    = 6'h3c;
   localparam logic [5:0] ID_READ   = 6'h3d;
   localparam logic [5:0] ID_EXT    = 6'h3f;
   localparam logic [7:0] APP_MARK  = 8'h80;
   localparam logic [6:0] CMD_ASSIGN = 7'h11;
   localparam logic [3:0] SLOT_GP2 = 4'h0, SLOT_GP4 = 4'h1, SLOT_RPOS = 4'h2, SLOT_RBRIEF = 4'h3;
   localparam logic [3:0] SLOT_MOVE = 4'h4, SLOT_CM1 = 4'h5, SLOT_CM2 = 4'h6, SLOT_CM4 = 4'h7;
   localparam logic [3:0] SLOT_PREP = 4'h8, SLOT_MSET = 4'h9;
   localparam logic [9:0] ADDR_SLOTS = 10'h20c;
   localparam logic [6:0] CMD_RPOS = 7'h00, CMD_RFULL = 7'h01, CMD_RFUSE = 7'h02, CMD_RBRIEF = 7'h03;
   localparam logic [6:0] CMD_SAFE = 7'h04, CMD_HALT = 7'h05, CMD_ZERO = 7'h06, CMD_REF = 7'h08;
   localparam logic [6:0] CMD_WDRV = 7'h09, CMD_WFUSE = 7'h10, CMD_WSTALL = 7'h16, CMD_MOVE = 7'h0b;
   localparam logic [6:0] CMD_CM1 = 7'h0c, CMD_CM2 = 7'h0d, CMD_CM4 = 7'h0e, CMD_MSET = 7'h2f;
   localparam logic [6:0] CMD_RAMP = 7'h0f, CMD_NONE = 7'h7f;
   localparam logic [7:0] OFS_NODE = 8'h00, OFS_STATUS = 8'h04, OFS_TABLE = 8'h40;
   localparam logic [6:0] NODE_RESET = 7'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0, RESP_SLVERR = 2'h2;

   typedef struct packed { logic valid; logic [7:0] pid; } header_type;
   typedef struct packed { logic valid; logic [7:0] pid; logic [1:8][7:0] data; } frame_type;
   typedef struct packed
   {
      logic       valid;
      logic       indirect;
      logic [3:0] slot;
      logic [6:0] cmd;
      logic [5:0] frame_id;
   } response_type;
   typedef struct packed
   {
      logic       valid;
      logic       from_slot;
      logic       known;
      logic [3:0] slot;
      logic [6:0] code;
   } command_type;

   function automatic logic pid_ok(input logic [7:0] p);
      pid_ok = (p[6] == (p[0] ^ p[1] ^ p[2] ^ p[4])) && (p[7] == !(p[1] ^ p[3] ^ p[4] ^ p[5]));
   endfunction

   function automatic logic cmd_known(input logic [6:0] c);
      case (c)
         CMD_RPOS, CMD_RFULL, CMD_RFUSE, CMD_RBRIEF, CMD_SAFE, CMD_HALT, CMD_ZERO, CMD_REF,
         CMD_RAMP, CMD_WDRV, CMD_WFUSE, CMD_WSTALL, CMD_MOVE, CMD_CM1, CMD_CM2, CMD_CM4,
         CMD_MSET, CMD_ASSIGN: cmd_known = 1'b1;
         default: cmd_known = 1'b0;
      endcase
   endfunction

   function automatic logic [6:0] slot_code(input logic [3:0] s);
      case (s)
         SLOT_RPOS:   slot_code = CMD_RPOS;
         SLOT_RBRIEF: slot_code = CMD_RBRIEF;
         SLOT_MOVE:   slot_code = CMD_MOVE;
         SLOT_CM1:    slot_code = CMD_CM1;
         SLOT_CM2:    slot_code = CMD_CM2;
         SLOT_CM4:    slot_code = CMD_CM4;
         SLOT_MSET:   slot_code = CMD_MSET;
         default:     slot_code = CMD_NONE;
      endcase
   endfunction
endpackage
`default_nettype wire

// >>> sim/lin_master_model.sv
// LIN master stand-in: hands parsed headers and frames to the node, one pulse each
// assumes the node samples HDR and FRAME on the rising edge of CLK
`timescale 1ns/10ps
`default_nettype none
module lin_master_model
(
   input  wire logic                    CLK,
   output var  lin_dyn_pkg::header_type HDR,
   output var  lin_dyn_pkg::frame_type  FRAME
);
   import lin_dyn_pkg::*;

   // parity bits 7:6 over the six id bits
   function automatic logic [7:0] protect(input logic [5:0] id);
      protect = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
   endfunction

   initial
   begin
      HDR   = '0;
      FRAME = '0;
   end

   // released fields are inverted so stale bytes never pass for fresh ones
   task automatic header(input logic [5:0] id);
      @(posedge CLK);
      HDR <= {1'b1, protect(id)};
      @(posedge CLK);
      HDR <= {1'b0, ~protect(id)};
   endtask

   // wrong parity on purpose, to see it ignored
   task automatic bad_header(input logic [5:0] id);
      @(posedge CLK);
      HDR <= {1'b1, protect(id) ^ 8'h80};
      @(posedge CLK);
      HDR <= {1'b0, ~protect(id)};
   endtask

   // a nonzero flip spoils the parity on purpose
   task automatic frame(input logic [5:0] id, input logic [1:8][7:0] d, input logic [7:0] flip = 8'h00);
      @(posedge CLK);
      FRAME <= {1'b1, protect(id) ^ flip, d};
      @(posedge CLK);
      FRAME <= {1'b0, ~protect(id), ~d};
   endtask

   // pair 1 is element 0
   task automatic assign_ids(input logic bc, input logic [6:0] ad, input logic [0:3][3:0] p,
                             input logic [0:3][5:0] i);
      frame(ID_CMD, {APP_MARK, 1'b1, CMD_ASSIGN, bc, ad,
                     i[0][3:0], p[0], i[1][1:0], p[1], i[0][5:4],
                     p[2], i[1][5:2], p[3][1:0], i[2], i[3], p[3][3:2]});
   endtask
endmodule
`default_nettype wire

// >>> sim/tb_lin_dynamic_id_assignment.sv
// self-checking bench: frames from the master model, registers over AXI4-Lite
// assumes lin_dyn_pkg and lin_master_model are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_lin_dynamic_id_assignment;
   import lin_dyn_pkg::*;
   typedef struct packed
   {
      logic [5:0] id;
      logic [7:0] d1;
      logic [7:0] d2;
      logic [1:0] fk;
      logic [3:0] sl;
      logic [6:0] cd;
   } row_type;
   // 0x3c rows carry the code in d2; slot rows carry node address 0x12 in d2
   localparam row_type ROWS [21] = '{
      {6'h3c, 8'h80, 8'h84, 2'b01, 4'h0, 7'h04}, {6'h3c, 8'h80, 8'h85, 2'b01, 4'h0, 7'h05},
      {6'h3c, 8'h80, 8'h86, 2'b01, 4'h0, 7'h06}, {6'h3c, 8'h80, 8'h88, 2'b01, 4'h0, 7'h08},
      {6'h3c, 8'h80, 8'h8f, 2'b01, 4'h0, 7'h0f}, {6'h3c, 8'h80, 8'h89, 2'b01, 4'h0, 7'h09},
      {6'h3c, 8'h80, 8'h90, 2'b01, 4'h0, 7'h10}, {6'h3c, 8'h80, 8'h96, 2'b01, 4'h0, 7'h16},
      {6'h3c, 8'h80, 8'h8b, 2'b01, 4'h0, 7'h0b}, {6'h3c, 8'h80, 8'h8c, 2'b01, 4'h0, 7'h0c},
      {6'h3c, 8'h80, 8'h8d, 2'b01, 4'h0, 7'h0d}, {6'h3c, 8'h80, 8'h8e, 2'b01, 4'h0, 7'h0e},
      {6'h3c, 8'h80, 8'haf, 2'b01, 4'h0, 7'h2f}, {6'h3c, 8'h80, 8'h87, 2'b00, 4'h0, 7'h07},
      {6'h2b, 8'h80, 8'h92, 2'b11, 4'h4, 7'h0b}, {6'h09, 8'h80, 8'h92, 2'b11, 4'h5, 7'h0c},
      {6'h29, 8'h80, 8'h92, 2'b11, 4'h6, 7'h0d}, {6'h39, 8'h80, 8'h92, 2'b11, 4'h7, 7'h0e},
      {6'h32, 8'h80, 8'h92, 2'b11, 4'h9, 7'h2f}, {6'h18, 8'h85, 8'h92, 2'b11, 4'h0, 7'h05},
      {6'h28, 8'h8f, 8'h92, 2'b11, 4'h1, 7'h0f}};
   localparam logic [5:0] TAB [10] = '{6'h18, 6'h28, 6'h22, 6'h00, 6'h2a, 6'h09, 6'h29, 6'h39, 6'h1a, 6'h30};

   logic         clk, resetn;
   header_type   hdr;
   frame_type    frm;
   response_type resp, last_resp;
   command_type  cmd, last_cmd;
   logic [7:0]   awaddr, araddr;
   logic [31:0]  wdata, rdata, d;
   logic [3:0]   wstrb;
   logic         awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [1:0]   bresp, rresp, r;
   int           fail_count, total_checks, n_resp, n_cmd, n0;

   lin_dynamic_id_assignment dut (.CLK(clk), .RESETN(resetn), .HDR(hdr), .FRAME(frm), .RESP(resp), .CMD(cmd),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready));
   lin_master_model lm (.CLK(clk), .HDR(hdr), .FRAME(frm));

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // one-cycle pulses are latched here so tests can look later
   always @(posedge clk)
   begin
      if (resp.valid === 1'b1)
      begin
         last_resp <= resp;
         n_resp    <= n_resp + 1;
      end
      if (cmd.valid === 1'b1)
      begin
         last_cmd <= cmd;
         n_cmd    <= n_cmd + 1;
      end
   end

   task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
      total_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      bit fin;
      fin = 0;
      @(posedge clk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
      while (!fin)
      begin
         @(posedge clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1)
         begin
            rs = bresp;
            bready <= 1'b0;
            fin = 1;
         end
      end
      // next write no sooner than two cycles after the response
      repeat (2) @(posedge clk);
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      bit fin;
      fin = 0;
      @(posedge clk);
      {araddr, arvalid, rready} <= {a, 2'b11};
      while (!fin)
      begin
         @(posedge clk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1)
         begin
            v = rdata;
            rs = rresp;
            rready <= 1'b0;
            fin = 1;
         end
      end
      @(posedge clk);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      logic [1:0]  rs;
      axi_rd(a, v, rs);
      chk({rs, v}, {RESP_OKAY, exp}, "register read");
   endtask

   task automatic hdr_chk(input logic [5:0] id, input logic hit, input logic [11:0] exp);
      int n;
      n = n_resp;
      lm.header(id);
      repeat (2) @(posedge clk);
      chk(n_resp - n, hit, "answer count");
      if (hit) chk({last_resp.frame_id, last_resp.indirect, last_resp.slot, last_resp.cmd}, {id, exp}, "answer fields");
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      #40000;
      fail_count++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      tally_and_finish;
   end

   initial
   begin
      {resetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      {fail_count, total_checks, n_resp, n_cmd} = '0;
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      repeat (2) @(posedge clk);
      rd_chk(OFS_NODE, 32'h0);
      rd_chk(OFS_STATUS, 32'h0);
      rd_chk(OFS_TABLE + 8'h08, 32'h0);
      axi_rd(8'h3c, d, r);
      chk({r, d}, {RESP_SLVERR, 32'h0}, "unmapped read");
      axi_wr(8'h08, 32'h5, r);
      chk(r, RESP_SLVERR, "unmapped write");
      $display("test reset done");

      // three frames fill all ten slots; slot 2 written twice in the last one
      lm.assign_ids(1'b0, 7'h55, {4'h2, 4'h3, 4'h4, 4'h8}, {6'h20, 6'h00, 6'h2a, 6'h1a});
      lm.assign_ids(1'b0, 7'h55, {4'h0, 4'h1, 4'h5, 4'h6}, {6'h18, 6'h28, 6'h09, 6'h29});
      lm.assign_ids(1'b0, 7'h55, {4'h7, 4'h9, 4'h2, 4'h2}, {6'h39, 6'h30, 6'h21, 6'h22});
      for (int s = 0; s < NUM_SLOTS; s++)
         rd_chk(OFS_TABLE + 8'(4 * s), {23'h0, 1'b1, 2'h0, TAB[s]});
      $display("test table fill done");

      axi_wr(OFS_NODE, 32'h12, r);
      chk(r, RESP_OKAY, "node write");
      rd_chk(OFS_NODE, 32'h12);
      lm.assign_ids(1'b1, 7'h13, {4{4'h4}}, {4{6'h11}});
      lm.frame(ID_CMD, {8'h00, 8'h91, 8'h00, 40'h1451441145});
      lm.frame(ID_CMD, {8'h80, 8'h11, 8'h00, 40'h1451441145});
      lm.frame(6'h3b, {8'h80, 8'h91, 8'h00, 40'h1451441145});
      lm.frame(ID_CMD, {8'h80, 8'h91, 8'h00, 40'h1451441145}, 8'h40);
      rd_chk(OFS_TABLE + 8'h10, 32'h12a);
      lm.assign_ids(1'b1, 7'h12, {4'h4, 4'ha, 4'hf, 4'h3}, {6'h2b, 6'h01, 6'h02, 6'h3c});
      lm.assign_ids(1'b0, 7'h00, {4'h2, 4'h5, 4'h6, 4'h7}, {6'h3f, 6'h09, 6'h29, 6'h39});
      rd_chk(OFS_TABLE + 8'h10, 32'h12b);
      rd_chk(OFS_TABLE + 8'h0c, 32'h100);
      rd_chk(OFS_TABLE + 8'h08, 32'h122);
      lm.assign_ids(1'b0, 7'h00, {4'ha, 4'hb, 4'hc, 4'hf}, {6'h01, 6'h02, 6'h03, 6'h04});
      axi_rd(OFS_STATUS, d, r);
      chk(d[23:8], 16'h0806, "status counts");
      $display("test addressing done");

      hdr_chk(6'h22, 1'b1, {1'b0, 4'h2, 7'h00});
      hdr_chk(6'h23, 1'b0, 12'h0);
      hdr_chk(6'h02, 1'b1, {1'b0, 4'h3, 7'h03});
      hdr_chk(6'h2b, 1'b0, 12'h0);
      hdr_chk(ID_CMD, 1'b0, 12'h0);
      lm.frame(ID_CMD, {8'h80, 8'h81, 8'h92, 40'hffffffffff});
      hdr_chk(ID_READ, 1'b1, {1'b1, 4'h8, 7'h01});
      hdr_chk(ID_READ, 1'b0, 12'h0);
      lm.frame(ID_CMD, {8'h80, 8'h80, 8'h93, 40'hffffffffff});
      hdr_chk(ID_READ, 1'b0, 12'h0);
      lm.frame(6'h1a, {8'h82, 8'h12, 48'hffffffffffff});
      lm.bad_header(ID_READ);
      hdr_chk(ID_READ, 1'b1, {1'b1, 4'h8, 7'h02});
      lm.frame(ID_CMD, {8'h80, 8'h80, 8'h92, 40'hffffffffff});
      lm.header(6'h10);
      hdr_chk(ID_READ, 1'b0, 12'h0);
      $display("test read answers done");

      foreach (ROWS[k])
      begin
         n0 = n_cmd;
         lm.frame(ROWS[k].id, {ROWS[k].d1, ROWS[k].d2, 8'h00, 40'hffffffffff});
         repeat (2) @(posedge clk);
         chk(n_cmd - n0, 1, "command count");
         chk({last_cmd.from_slot, last_cmd.known, last_cmd.code}, {ROWS[k].fk, ROWS[k].cd}, "command");
         if (ROWS[k].fk[1]) chk(last_cmd.slot, ROWS[k].sl, "command slot");
      end
      $display("test command decode done");

      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (2) @(posedge clk);
      rd_chk(OFS_NODE, 32'h0);
      rd_chk(OFS_TABLE + 8'h10, 32'h0);
      $display("test second reset done");
      tally_and_finish;
   end
endmodule
`default_nettype wire
